/* File: hlm_channel.sv */
// Serial channel framer with line coding, modem handshake and special modes
`default_nettype none
module hlm_channel (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Serial line
  input wire logic sclk_i,
  input wire logic rxd_i,
  output logic txd_o,
  // Modem control
  input wire logic send_permit_in_n_i,
  input wire logic carrier_sense_in_i,
  output logic send_request_out_n_o,
  // DMA request
  output logic dma_req_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a change counts once stages two and three agree
  logic [3:0] s1_reg, s2_reg, s3_reg, lvl_reg, lvl_d_reg;
  wire [3:0] pin_raw = {carrier_sense_in_i, send_permit_in_n_i, rxd_i, sclk_i};
  wire [3:0] lvl_next = (s2_reg & s3_reg) | (lvl_reg & (s2_reg ^ s3_reg));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      lvl_reg <= '0;
      lvl_d_reg <= '0;
    end else begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= lvl_next;
      lvl_d_reg <= lvl_reg;
    end
  end

  wire sclk_rise = lvl_reg[hlm_pkg::P_SCLK] & ~lvl_d_reg[hlm_pkg::P_SCLK];
  wire sclk_fall = ~lvl_reg[hlm_pkg::P_SCLK] & lvl_d_reg[hlm_pkg::P_SCLK];
  wire permit = ~lvl_reg[hlm_pkg::P_PERMIT];
  wire permit_chg = lvl_reg[hlm_pkg::P_PERMIT] ^ lvl_d_reg[hlm_pkg::P_PERMIT];

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after the strobe, effects at the ack edge
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [hlm_pkg::CFG_W-1:0] cfg_reg;
  logic [7:0] limit_reg;
  logic [11:0] txcnt_reg, dma_left_reg;
  wire req = wb_cyc_i & wb_stb_i;
  wire wr_ev = req & ack_reg & wb_we_i;
  wire rd_ev = req & ack_reg & ~wb_we_i;
  wire [31:0] wm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] wv = wb_dat_i & wm;
  wire hit_cfg = wb_adr_i == hlm_pkg::OFS_CFG;
  wire hit_cmd = wb_adr_i == hlm_pkg::OFS_CMD;
  wire hit_stat = wb_adr_i == hlm_pkg::OFS_STAT;
  wire hit_txd = wb_adr_i == hlm_pkg::OFS_TXD;
  wire hit_rxd = wb_adr_i == hlm_pkg::OFS_RXD;
  wire hit_rxlow = wb_adr_i == hlm_pkg::OFS_RXLOW;
  wire hit_limit = wb_adr_i == hlm_pkg::OFS_LIMIT;
  wire hit_txcnt = wb_adr_i == hlm_pkg::OFS_TXCNT;
  wire hit_rxcnt = wb_adr_i == hlm_pkg::OFS_RXCNT;
  wire [7:0] cmd = (wr_ev && hit_cmd) ? wv[7:0] : 8'h00;
  wire do_reset = |(cmd & hlm_pkg::CMD_TX_RESET);
  wire do_frame = |(cmd & hlm_pkg::CMD_TX_FRAME);

  wire nrzi = cfg_reg[hlm_pkg::B_NRZI];
  wire bus = cfg_reg[hlm_pkg::B_BUS];
  wire one_ins = cfg_reg[hlm_pkg::B_ONE_INS] & bus;
  wire inv = cfg_reg[hlm_pkg::B_INV] & ~nrzi;
  wire transp = cfg_reg[hlm_pkg::B_MODE +: 2] == hlm_pkg::MODE_TRANSP;
  wire [2:0] clkm = cfg_reg[hlm_pkg::B_CLKM +: 3];
  wire dma = cfg_reg[hlm_pkg::B_DMA];
  wire cont = cfg_reg[hlm_pkg::B_CONT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg <= '0;
      limit_reg <= '0;
      txcnt_reg <= '0;
    end else if (wr_ev) begin
      if (hit_cfg) cfg_reg <= (cfg_reg & ~wm[hlm_pkg::CFG_W-1:0]) | wv[hlm_pkg::CFG_W-1:0];
      if (hit_limit) limit_reg <= (limit_reg & ~wm[7:0]) | wv[7:0];
      if (hit_txcnt) txcnt_reg <= (txcnt_reg & ~wm[11:0]) | wv[11:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit FIFO and framer
  hlm_pkg::hlm_tx_e tx_st_reg;
  logic [7:0] txm [hlm_pkg::DEPTH];
  logic [hlm_pkg::PTR_W-1:0] tx_wr_reg, tx_rd_reg, tx_base_reg, sent_reg;
  logic [7:0] tx_sh_reg;
  logic [2:0] tx_cnt_reg, ones_reg, zeros_reg;
  logic pend_reg, msg_end_reg, rep_reg, txd_reg, bus_idle_reg;

  wire [hlm_pkg::PTR_W-1:0] tx_used = tx_wr_reg - tx_base_reg;
  wire tx_full = tx_used == hlm_pkg::PTR_W'(hlm_pkg::DEPTH);
  wire tx_have = tx_wr_reg != tx_rd_reg;
  wire push_tx = wr_ev && hit_txd && wb_sel_i[0] && !tx_full;
  wire can_load = tx_have | rep_reg;
  wire [hlm_pkg::PTR_W-1:0] ldp = tx_have ? tx_rd_reg : tx_base_reg;
  wire [hlm_pkg::PTR_W-1:0] ldp_inc = ldp + 6'h01;
  wire in_data = tx_st_reg == hlm_pkg::TX_DATA;
  wire stuffing = in_data && !transp;
  wire ins0 = stuffing && ones_reg == hlm_pkg::STUFF_ONES;
  wire ins1 = stuffing && !ins0 && one_ins && zeros_reg == hlm_pkg::INS_ZEROS;
  wire tx_bit = (tx_st_reg == hlm_pkg::TX_IDLE) | ins1 | (!ins0 & tx_sh_reg[0]);
  wire consume = sclk_rise && tx_st_reg != hlm_pkg::TX_IDLE && !ins0 && !ins1;
  wire byte_done = consume && tx_cnt_reg == 3'h0;
  wire dma_done = dma && !cont && dma_left_reg == 12'h000;
  wire end_ok = msg_end_reg | dma_done | (transp & ~dma);
  wire finish = in_data && byte_done && !can_load;
  wire tx_end_ev = finish && end_ok && transp;
  wire underrun = finish && !end_ok;
  wire go = sclk_rise && pend_reg && permit && (!bus || bus_idle_reg) && can_load;
  wire lost = tx_st_reg != hlm_pkg::TX_IDLE && !permit;
  wire lost_late = lost && sent_reg > hlm_pkg::INFO_LIMIT;
  wire load = (go && tx_st_reg == hlm_pkg::TX_IDLE && transp) ||
              (byte_done && can_load &&
               (tx_st_reg == hlm_pkg::TX_OPEN || in_data));

  always_ff @(posedge clk_i) begin
    if (push_tx) txm[tx_wr_reg[4:0]] <= wv[7:0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || do_reset || lost_late) begin
      tx_st_reg <= hlm_pkg::TX_IDLE;
      tx_wr_reg <= '0;
      tx_rd_reg <= '0;
      tx_base_reg <= '0;
      pend_reg <= 1'b0;
      msg_end_reg <= 1'b0;
      rep_reg <= 1'b0;
      sent_reg <= '0;
      tx_sh_reg <= '0;
      tx_cnt_reg <= '0;
    end else begin
      if (push_tx) tx_wr_reg <= tx_wr_reg + 6'h01;
      if (do_frame) begin
        pend_reg <= 1'b1;
        msg_end_reg <= |(cmd & hlm_pkg::CMD_MSG_END);
        rep_reg <= |(cmd & hlm_pkg::CMD_REPEAT) & transp;
      end
      if (lost) begin
        tx_rd_reg <= tx_base_reg;
        tx_st_reg <= hlm_pkg::TX_IDLE;
      end else if (load) begin
        tx_sh_reg <= txm[ldp[4:0]];
        tx_rd_reg <= ldp_inc;
        tx_cnt_reg <= hlm_pkg::LAST_BIT;
        tx_st_reg <= hlm_pkg::TX_DATA;
        if (sent_reg != 6'h3F) sent_reg <= sent_reg + 6'h01;
        // Past 32 bytes a retry is impossible, so free the held bytes
        if (!rep_reg && sent_reg >= hlm_pkg::INFO_LIMIT) tx_base_reg <= ldp_inc;
      end else if (go && tx_st_reg == hlm_pkg::TX_IDLE) begin
        tx_sh_reg <= hlm_pkg::FLAG;
        tx_cnt_reg <= hlm_pkg::LAST_BIT;
        tx_st_reg <= hlm_pkg::TX_OPEN;
        sent_reg <= '0;
      end else if (finish && end_ok && !transp) begin
        tx_sh_reg <= hlm_pkg::FLAG;
        tx_cnt_reg <= hlm_pkg::LAST_BIT;
        tx_st_reg <= hlm_pkg::TX_CLOSE;
        tx_base_reg <= tx_rd_reg;
      end else if (finish || (byte_done && tx_st_reg == hlm_pkg::TX_CLOSE)) begin
        tx_st_reg <= hlm_pkg::TX_IDLE;
        pend_reg <= 1'b0;
        tx_base_reg <= tx_rd_reg;
      end else if (consume) begin
        tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
        tx_cnt_reg <= tx_cnt_reg - 3'h1;
      end
    end
  end

  // DMA requests when enabled and the FIFO is wholly free, while dma_left_reg is nonzero or cont is set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dma_left_reg <= '0;
      dma_req_o <= 1'b0;
    end else begin
      if (wr_ev && hit_txcnt) dma_left_reg <= (txcnt_reg & ~wm[11:0]) | wv[11:0];
      else if (push_tx && dma && dma_left_reg != 12'h000) dma_left_reg <= dma_left_reg - 12'h001;
      dma_req_o <= dma && tx_used == 6'h00 && (cont || dma_left_reg != 12'h000);
    end
  end

  // Line coder: stuffing counters and output bit on the serial clock rise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ones_reg <= '0;
      zeros_reg <= '0;
      txd_reg <= 1'b1;
    end else if (sclk_rise) begin
      if (!stuffing) begin
        ones_reg <= '0;
        zeros_reg <= '0;
      end else if (ins1) begin
        zeros_reg <= '0;
      end else if (ins0) begin
        ones_reg <= '0;
        zeros_reg <= zeros_reg + 3'h1;
      end else begin
        ones_reg <= tx_bit ? ones_reg + 3'h1 : 3'h0;
        zeros_reg <= tx_bit ? 3'h0 : zeros_reg + 3'h1;
      end
      txd_reg <= nrzi ? (txd_reg ^ ~tx_bit) : (tx_bit ^ inv);
    end
  end
  assign txd_o = txd_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) send_request_out_n_o <= 1'b1;
    else if (cfg_reg[hlm_pkg::B_REQ_FORCE]) send_request_out_n_o <= cfg_reg[hlm_pkg::B_REQ_LEVEL];
    else send_request_out_n_o <= ~pend_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver: decode, one deletion, flag search, zero deletion, assembly
  logic rx_run_reg, rx_prev_reg, in_frame_reg;
  logic [3:0] idle_cnt_reg, vcnt_reg;
  logic [2:0] rz_reg, rones_reg, rbit_reg;
  logic [7:0] win_reg, rx_sh_reg, rxlow_reg;
  logic [11:0] rx_cnt_reg, rxcnt_rep_reg;
  logic [7:0] rxm [hlm_pkg::DEPTH];
  logic [hlm_pkg::PTR_W-1:0] rx_wr_reg, rx_rd_reg;

  wire carrier_ok = hlm_pkg::CARRIER_AUX_MODES[clkm] |
                    (hlm_pkg::CARRIER_TXC_MODES[clkm] & ~cfg_reg[hlm_pkg::B_TXC_DIR]);
  wire rx_en = cfg_reg[hlm_pkg::B_RX_ACTIVE] | rx_run_reg | transp;
  wire rx_ev = sclk_fall && rx_en;
  wire line = lvl_reg[hlm_pkg::P_RXD];
  wire raw = nrzi ? ~(line ^ rx_prev_reg) : (line ^ inv);
  wire onedel = !transp && one_ins && rz_reg == hlm_pkg::INS_ZEROS;
  wire hb = rx_ev && !onedel && !transp;
  wire [7:0] wn = {win_reg[6:0], raw};
  wire is_flag = wn == hlm_pkg::FLAG;
  wire is_abort = wn[6:0] == hlm_pkg::ABORT7;
  wire dbit = win_reg[7];
  wire dvalid = hb && !is_flag && !is_abort && vcnt_reg == hlm_pkg::WIN_FULL && in_frame_reg;
  wire hdata = dvalid && !(rones_reg == hlm_pkg::STUFF_ONES && !dbit);
  wire tbit = rx_ev && transp;
  wire bit_in = tbit | hdata;
  wire byte_in = bit_in && rbit_reg == hlm_pkg::LAST_BIT;
  wire [7:0] sh_next = {transp ? raw : dbit, rx_sh_reg[7:1]};
  wire [7:0] lblk = {1'b0, limit_reg[6:0]} + 8'h01;
  wire [12:0] lim = {lblk, hlm_pkg::BLOCK_PAD};
  wire over = limit_reg[7] && byte_in && !transp &&
              ({1'b0, rx_cnt_reg} + hlm_pkg::STATUS_AND_BYTE > lim);
  wire rx_abort = (hb && !is_flag && is_abort && in_frame_reg) || over;
  wire rx_end = (hb && is_flag && in_frame_reg && rx_cnt_reg != 12'h000) || rx_abort;
  wire rx_empty = rx_wr_reg == rx_rd_reg;
  wire rx_full = (rx_wr_reg - rx_rd_reg) == hlm_pkg::PTR_W'(hlm_pkg::DEPTH);
  wire push_rx = byte_in && (!transp || cfg_reg[hlm_pkg::B_ADDR_MODE]) && !rx_full;
  wire pop_rx = rd_ev && hit_rxd && !rx_empty;

  always_ff @(posedge clk_i) begin
    if (rst_i || !cfg_reg[hlm_pkg::B_AUTO_START]) rx_run_reg <= 1'b0;
    else if (carrier_ok && lvl_reg[hlm_pkg::P_CARRIER]) rx_run_reg <= 1'b1;
  end

  // Bus monitor runs on every falling edge, receiver enabled or not
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idle_cnt_reg <= '0;
      bus_idle_reg <= 1'b0;
      rx_prev_reg <= 1'b0;
    end else if (sclk_fall) begin
      rx_prev_reg <= line;
      if (!raw) idle_cnt_reg <= '0;
      else if (idle_cnt_reg != hlm_pkg::IDLE_ONES) idle_cnt_reg <= idle_cnt_reg + 4'h1;
      bus_idle_reg <= raw && idle_cnt_reg >= hlm_pkg::IDLE_ONES - 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push_rx) rxm[rx_wr_reg[4:0]] <= sh_next;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !rx_en) begin
      win_reg <= '0;
      vcnt_reg <= '0;
      in_frame_reg <= 1'b0;
      rz_reg <= '0;
      rones_reg <= '0;
      rbit_reg <= '0;
      rx_sh_reg <= '0;
      rx_cnt_reg <= '0;
    end else begin
      if (rx_ev) rz_reg <= (onedel || raw) ? 3'h0 : rz_reg + 3'h1;
      if (hb) begin
        win_reg <= wn;
        if (is_flag) begin
          vcnt_reg <= '0;
          in_frame_reg <= 1'b1;
          rbit_reg <= '0;
          rones_reg <= '0;
          rx_cnt_reg <= '0;
        end else if (is_abort) begin
          in_frame_reg <= 1'b0;
        end else if (vcnt_reg != hlm_pkg::WIN_FULL) begin
          vcnt_reg <= vcnt_reg + 4'h1;
        end
      end
      if (dvalid) rones_reg <= (dbit && rones_reg != hlm_pkg::STUFF_ONES) ? rones_reg + 3'h1 : 3'h0;
      if (bit_in) begin
        rx_sh_reg <= sh_next;
        rbit_reg <= rbit_reg + 3'h1;
      end
      if (byte_in && !transp) rx_cnt_reg <= rx_cnt_reg + 12'h001;
      if (over) in_frame_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_wr_reg <= '0;
      rx_rd_reg <= '0;
      rxlow_reg <= '0;
      rxcnt_rep_reg <= '0;
    end else begin
      if (push_rx) rx_wr_reg <= rx_wr_reg + 6'h01;
      if (pop_rx) rx_rd_reg <= rx_rd_reg + 6'h01;
      if (byte_in && transp) rxlow_reg <= sh_next;
      if (rx_end) rxcnt_rep_reg <= rx_cnt_reg + {11'h000, over};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status: hardware set wins over a same-cycle write-one clear
  logic [hlm_pkg::ST_W-1:0] st_reg;
  logic [hlm_pkg::ST_W-1:0] st_set;
  wire [hlm_pkg::ST_W-1:0] st_clr = (wr_ev && hit_stat) ? wv[hlm_pkg::ST_W-1:0] : '0;
  always_comb begin
    st_set = '0;
    st_set[hlm_pkg::ST_PERMIT_CHG] = permit_chg & cfg_reg[hlm_pkg::B_PERMIT_IE];
    st_set[hlm_pkg::ST_TX_ABORT] = lost_late;
    st_set[hlm_pkg::ST_MSG_END] = rx_end;
    st_set[hlm_pkg::ST_ABORTED] = rx_abort;
    st_set[hlm_pkg::ST_UNDERRUN] = underrun;
    st_set[hlm_pkg::ST_TX_END] = tx_end_ev;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) st_reg <= '0;
    else st_reg <= (st_reg & ~st_clr) | st_set;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses read zero and still acknowledge
  wire [31:0] rdata =
    hit_cfg ? 32'(cfg_reg) :
    hit_stat ? {12'h000, permit, rx_run_reg, pend_reg, bus_idle_reg, 9'h000, st_reg} :
    hit_txd ? 32'(6'(hlm_pkg::DEPTH) - tx_used) :
    hit_rxd ? {23'h00_0000, rx_empty, rxm[rx_rd_reg[4:0]]} :
    hit_rxlow ? 32'(rxlow_reg) :
    hit_limit ? 32'(limit_reg) :
    hit_txcnt ? 32'(txcnt_reg) :
    hit_rxcnt ? 32'(rxcnt_rep_reg) : 32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= '0;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (req & ~ack_reg) dat_reg <= rdata;
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

endmodule // hlm_channel
`default_nettype wire

/* File: hlm_pkg.sv */
// Shared constants and types for the serial channel line-coding block
`default_nettype none
package hlm_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_TXD = 8'h0C;
  localparam logic [7:0] OFS_RXD = 8'h10;
  localparam logic [7:0] OFS_RXLOW = 8'h14;
  localparam logic [7:0] OFS_LIMIT = 8'h18;
  localparam logic [7:0] OFS_TXCNT = 8'h1C;
  localparam logic [7:0] OFS_RXCNT = 8'h20;
  // Configuration bit positions
  localparam int CFG_W = 18;
  localparam int B_NRZI = 0;
  localparam int B_BUS = 1;
  localparam int B_ONE_INS = 2;
  localparam int B_INV = 3;
  localparam int B_MODE = 4;
  localparam int B_ADDR_MODE = 6;
  localparam int B_RX_ACTIVE = 7;
  localparam int B_CLKM = 8;
  localparam int B_TXC_DIR = 11;
  localparam int B_PERMIT_IE = 12;
  localparam int B_REQ_FORCE = 13;
  localparam int B_REQ_LEVEL = 14;
  localparam int B_AUTO_START = 15;
  localparam int B_DMA = 16;
  localparam int B_CONT = 17;
  // Command codes, one bit each
  localparam logic [7:0] CMD_TX_RESET = 8'h01;
  localparam logic [7:0] CMD_MSG_END = 8'h02;
  localparam logic [7:0] CMD_TX_FRAME = 8'h08;
  localparam logic [7:0] CMD_REPEAT = 8'h20;
  // Sticky status bits
  localparam int ST_W = 7;
  localparam int ST_PERMIT_CHG = 0;
  localparam int ST_TX_ABORT = 1;
  localparam int ST_MSG_END = 2;
  localparam int ST_ABORTED = 3;
  localparam int ST_UNDERRUN = 4;
  localparam int ST_TX_END = 6;
  // Mode and clock-mode selections
  localparam logic [1:0] MODE_TRANSP = 2'b11;
  localparam logic [7:0] CARRIER_AUX_MODES = 8'h0D;
  localparam logic [7:0] CARRIER_TXC_MODES = 8'hD0;
  // Pin indices in the synchroniser vector
  localparam int P_SCLK = 0;
  localparam int P_RXD = 1;
  localparam int P_PERMIT = 2;
  localparam int P_CARRIER = 3;
  // Line constants
  localparam int PTR_W = 6;
  localparam int DEPTH = 32;
  localparam logic [PTR_W-1:0] INFO_LIMIT = 6'h20;
  localparam logic [7:0] FLAG = 8'h7E;
  localparam logic [6:0] ABORT7 = 7'h7F;
  localparam logic [2:0] STUFF_ONES = 3'h5;
  localparam logic [2:0] INS_ZEROS = 3'h7;
  localparam logic [3:0] IDLE_ONES = 4'h8;
  localparam logic [3:0] WIN_FULL = 4'h8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [4:0] BLOCK_PAD = 5'h00;
  localparam logic [12:0] STATUS_AND_BYTE = 13'h0002;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_OPEN = 2'b01,
    TX_DATA = 2'b10,
    TX_CLOSE = 2'b11
  } hlm_tx_e;
endpackage
`default_nettype wire

/* File: hlm_checker.sv */
// Port-level property checker for the serial channel, bound to its top module
`default_nettype none
module hlm_checker (
  // Watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic sclk_i,
  input wire logic send_permit_in_n_i,
  input wire logic txd_o,
  input wire logic send_request_out_n_o,
  input wire logic dma_req_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [3:0] off_reg;
  logic [7:0] sh_reg;
  // Permit-off counter saturates so a long withdrawal never wraps back to zero
  always_ff @(posedge clk_i) begin
    if (rst_i || !send_permit_in_n_i) off_reg <= 4'h0;
    else if (off_reg != 4'hF) off_reg <= off_reg + 4'h1;
  end
  always_ff @(posedge clk_i) sh_reg <= {sh_reg[6:0], sclk_i};
  ////////////////////////////////////////////////////////////////////////////
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'hFC
    |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
  a_reset_idle: assert property (disable iff (1'b0) rst_i |=> txd_o
    && send_request_out_n_o && !dma_req_o) else $error("outputs not idle in reset");
  // Bus writes and permit loss may move the line at once, so they are excluded
  a_txd_on_rise: assert property ($changed(txd_o) && off_reg == 4'h0 && !$past(wb_ack_o)
    && !$past(wb_ack_o, 2) && !$past(wb_ack_o, 3) |-> (sh_reg[6:3] & ~sh_reg[7:4]) != 4'h0)
    else $error("line moved without clock rise");
  a_req_after_cmd: assert property ($fell(send_request_out_n_o) |-> $past(wb_ack_o)
    || $past(wb_ack_o, 2) || $past(wb_ack_o, 3)) else $error("request without command");
  a_quiet_no_permit: assert property (off_reg == 4'hF && !wb_ack_o && !$past(wb_ack_o)
    |-> $stable(txd_o)) else $error("line moved without permit");
  a_dma_drop: assert property (dma_req_o && wb_ack_o && wb_we_i
    && wb_adr_i == hlm_pkg::OFS_TXD |-> ##[1:3] !dma_req_o) else $error("dma request stuck");
endmodule // hlm_checker
bind hlm_channel hlm_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .sclk_i, .send_permit_in_n_i, .txd_o, .send_request_out_n_o,
  .dma_req_o);
`default_nettype wire

/* File: hlm_modem.sv */
// Behavioural modem: serial clock, permit and an echo of the line into receive
`default_nettype none
module hlm_modem (
  // Control from the bench
  input wire logic en_i,
  input wire logic drop_i,
  input wire logic txd_i,
  // Line side
  output logic sclk_o,
  output logic rxd_o,
  output logic permit_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic churn = 1'b0;
  // Offset start keeps the serial clock out of phase with the system clock
  initial begin
    sclk_o = 1'b0;
    #7;
    forever begin
      #160;
      sclk_o = en_i ? ~sclk_o : 1'b0;
    end
  end
  // Outside a session the receive line wanders, so a stale level is never trusted
  always #20 churn = ~churn;
  assign permit_n_o = !en_i || drop_i;
  assign rxd_o = en_i ? txd_i : churn;
endmodule // hlm_modem
`default_nettype wire

/* File: testbench.sv */
// Register-level bench for the serial channel with a looped-back modem
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) fail(); end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic en = 1'b0;
  logic drop = 1'b0;
  logic car = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] dout, rdat;
  logic ack, txd, sclk, rxd, pn, rqn, dma, s0, s1;
  int n_mismatch = 0;
  int checked = 0;
  hlm_channel uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack),
    .sclk_i(sclk), .rxd_i(rxd), .txd_o(txd), .send_permit_in_n_i(pn),
    .carrier_sense_in_i(car), .send_request_out_n_o(rqn), .dma_req_o(dma));
  hlm_modem u_modem (.en_i(en), .drop_i(drop), .txd_i(txd), .sclk_o(sclk), .rxd_o(rxd),
    .permit_n_o(pn));
  initial forever #20 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////
  task automatic fail();
    n_mismatch++;
    $display("MISMATCH at %0t: value differs", $time);
  endtask
  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // No wait limit of its own: a hung slave is caught by the watchdog
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= v;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rdat = dout;
    cyc <= 1'b0;
  endtask
  // Waits k serial clock rises, then lets the line settle; the settle stays under
  // one serial period so that back-to-back calls do not skip a bit
  task automatic bits(input int k);
    repeat (k) @(posedge sclk);
    repeat (7) @(posedge clk_i);
  endtask
  task automatic run_cyc(input logic [17:0] c, input logic [7:0] b, input logic [7:0] m);
    wb(1'b1, hlm_pkg::OFS_CFG, 32'(c));
    wb(1'b1, hlm_pkg::OFS_CMD, 32'(hlm_pkg::CMD_TX_RESET));
    wb(1'b1, hlm_pkg::OFS_TXD, 32'(b));
    wb(1'b1, hlm_pkg::OFS_CMD, 32'(m));
    bits(24);
    s0 = txd;
    bits(1);
    s1 = txd;
    wb(1'b0, hlm_pkg::OFS_RXLOW, 32'h0000_0000);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    en <= 1'b1;
    wb(1'b1, hlm_pkg::OFS_LIMIT, 32'h0000_0085);
    wb(1'b0, hlm_pkg::OFS_LIMIT, 32'h0000_0000);
    `CHK(rdat[7:0], 8'h85)
    wb(1'b0, 8'hFC, 32'h0000_0000);
    `CHK(rdat, 32'h0000_0000)
    wb(1'b1, hlm_pkg::OFS_CFG, 32'h0000_2000);
    bits(0);
    `CHK(rqn, 1'b0)
    wb(1'b1, hlm_pkg::OFS_CFG, 32'h0000_6000);
    bits(0);
    `CHK(rqn, 1'b1)
    $display("test regs and forced request done");
    wb(1'b1, hlm_pkg::OFS_CFG, 32'h0000_1000);
    drop <= 1'b1;
    wb(1'b1, hlm_pkg::OFS_TXD, 32'h0000_0055);
    wb(1'b1, hlm_pkg::OFS_CMD, 32'h0000_000A);
    bits(12);
    `CHK(rqn, 1'b0)
    `CHK(txd, 1'b1)
    wb(1'b0, hlm_pkg::OFS_STAT, 32'h0000_0000);
    `CHK(rdat[hlm_pkg::ST_PERMIT_CHG], 1'b1)
    wb(1'b1, hlm_pkg::OFS_STAT, 32'h0000_0001);
    drop <= 1'b0;
    bits(40);
    `CHK(rqn, 1'b1)
    wb(1'b0, hlm_pkg::OFS_STAT, 32'h0000_0000);
    `CHK(rdat[hlm_pkg::ST_PERMIT_CHG], 1'b1)
    wb(1'b0, hlm_pkg::OFS_TXD, 32'h0000_0000);
    `CHK(rdat[5:0], 6'h20)
    $display("test permit handshake done");
    wb(1'b1, hlm_pkg::OFS_CFG, 32'h0003_0000);
    wb(1'b1, hlm_pkg::OFS_TXCNT, 32'h0000_0000);
    bits(0);
    `CHK(dma, 1'b1)
    wb(1'b1, hlm_pkg::OFS_CFG, 32'h0001_0000);
    bits(0);
    `CHK(dma, 1'b0)
    wb(1'b1, hlm_pkg::OFS_CFG, 32'h0003_0000);
    bits(0);
    wb(1'b1, hlm_pkg::OFS_TXD, 32'h0000_0011);
    bits(0);
    `CHK(dma, 1'b0)
    $display("test dma requests done");
    wb(1'b1, hlm_pkg::OFS_CFG, 32'h0000_8000);
    bits(0);
    wb(1'b0, hlm_pkg::OFS_STAT, 32'h0000_0000);
    `CHK(rdat[18], 1'b0)
    car <= 1'b1;
    bits(0);
    wb(1'b0, hlm_pkg::OFS_STAT, 32'h0000_0000);
    `CHK(rdat[18], 1'b1)
    $display("test carrier auto start done");
    run_cyc(18'h0_0070, 8'h00, 8'h2A);
    `CHK({s0, s1}, 2'b00)
    `CHK(rdat[7:0], 8'h00)
    wb(1'b0, hlm_pkg::OFS_RXD, 32'h0000_0000);
    `CHK(rdat[8], 1'b0)
    wb(1'b1, hlm_pkg::OFS_CMD, 32'(hlm_pkg::CMD_TX_RESET));
    bits(12);
    `CHK(txd, 1'b1)
    wb(1'b1, hlm_pkg::OFS_STAT, 32'h0000_00FF);
    wb(1'b1, hlm_pkg::OFS_TXD, 32'h0000_0000);
    wb(1'b1, hlm_pkg::OFS_CMD, 32'(hlm_pkg::CMD_TX_FRAME));
    bits(30);
    wb(1'b0, hlm_pkg::OFS_STAT, 32'h0000_0000);
    `CHK(rdat[hlm_pkg::ST_TX_END], 1'b1)
    `CHK(txd, 1'b1)
    $display("test transparent modes done");
    run_cyc(18'h0_0231, 8'h00, 8'h2A);
    `CHK(s0 ^ s1, 1'b1)
    `CHK(rdat[7:0], 8'h00)
    run_cyc(18'h0_0038, 8'h00, 8'h2A);
    `CHK(s0, 1'b1)
    `CHK(rdat[7:0], 8'h00)
    $display("test line coding done");
    run_cyc(18'h1_0070, 8'h00, 8'h28);
    `CHK({s0, s1}, 2'b00)
    `CHK(rdat[7:0], 8'h00)
    $display("test dma cyclic done");
    close_out();
  end
  initial begin
    #500000;
    n_mismatch++;
    close_out();
  end
endmodule // testbench
`default_nettype wire
